// File: verilog/instr_timing_core.sv
/*
 Instruction sequencing core: fetch, decode, execute with cycle timing.
 Assumes a program memory answering one word per instruction cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_timing_consts.svh"

module instr_timing_core
  import core_timing_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int RAM_DEPTH = 256
) (
  input wire logic mclk,
  input wire logic reset,
  output logic [12:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic wake,
  output logic [7:0] acc_out,
  output logic zero_flag,
  output logic carry_flag,
  output logic halted,
  output logic wdt_clear,
  output logic [7:0] table_data,
  output logic instr_done
);
  import core_timing_pkg::*;

  initial begin
    if (STACK_DEPTH < 1 || STACK_DEPTH > 15) $error("bad stack depth");
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic opcode_type decode(input logic [15:0] w);
    logic [4:0] f;
    f = w[`OPC_MSB:`OPC_LSB];
    if (f > 5'(op_wdt_clear)) begin
      return op_nop;
    end
    return opcode_type'(f);
  endfunction : decode

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction : bit_mask

  // ----------------------------------------------------------
  // Sub blocks
  // ----------------------------------------------------------
  logic cycle_end;
  logic [7:0] ram_rdata;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ram_addr;

  phase_counter #(.PHASES(`PHASES_PER_CYCLE)) u_phase (
    .mclk(mclk),
    .reset(reset),
    .cycle_end(cycle_end)
  );

  data_ram #(.DEPTH(RAM_DEPTH)) u_ram (
    .mclk(mclk),
    .addr(ram_addr),
    .we(ram_we),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  core_state_type state_ff, nxt_state;
  logic [12:0] pc_ff, nxt_pc;
  logic [15:0] ir_ff, nxt_ir;
  logic [7:0] acc_ff, nxt_acc;
  logic z_ff, nxt_z;
  logic c_ff, nxt_c;
  logic [12:0] stack_ff [STACK_DEPTH];
  logic [12:0] nxt_stack [STACK_DEPTH];
  logic [3:0] sp_ff, nxt_sp;
  logic [7:0] tbl_ff, nxt_tbl;
  logic [12:0] ret_ff, nxt_ret;
  logic wdt_ff, nxt_wdt;
  logic done_ff, nxt_done;

  opcode_type op;
  logic [7:0] maddr;
  logic [2:0] bsel;
  logic [7:0] mval;
  logic [8:0] sum;
  logic [7:0] res;

  assign op = decode(ir_ff);
  assign maddr = ir_ff[`ADDR_MSB:`ADDR_LSB];
  assign bsel = ir_ff[`BIT_MSB:`BIT_LSB];
  assign mval = ram_rdata;
  assign ram_addr = maddr;

  // ----------------------------------------------------------
  // Wake pin synchroniser
  // ----------------------------------------------------------
  logic wake_meta_ff, nxt_wake_meta;
  logic wake_sync_ff, nxt_wake_sync;

  always_comb begin
    nxt_wake_meta = wake;
    nxt_wake_sync = wake_meta_ff;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_meta_ff <= 1'b0;
      wake_sync_ff <= 1'b0;
    end else begin
      wake_meta_ff <= nxt_wake_meta;
      wake_sync_ff <= nxt_wake_sync;
    end
  end

  // ----------------------------------------------------------
  // Execute
  // ----------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_ir = ir_ff;
    nxt_acc = acc_ff;
    nxt_z = z_ff;
    nxt_c = c_ff;
    nxt_stack = stack_ff;
    nxt_sp = sp_ff;
    nxt_tbl = tbl_ff;
    nxt_ret = ret_ff;
    nxt_wdt = 1'b0;
    nxt_done = 1'b0;
    ram_we = 1'b0;
    ram_wdata = 8'h00;
    sum = 9'h000;
    res = 8'h00;
    if (cycle_end) begin
      case (state_ff)
        st_halted: begin
          if (wake_sync_ff) begin
            // Resume with the word after the halt
            nxt_ir = prog_data;
            nxt_pc = pc_ff + 13'h0001;
            nxt_state = st_run;
          end
        end
        st_flush: begin
          // Prefetched word is dropped; fetch from new address
          nxt_ir = prog_data;
          nxt_pc = pc_ff + 13'h0001;
          nxt_state = st_run;
          nxt_done = 1'b1;
        end
        st_table: begin
          nxt_tbl = prog_data[7:0];
          nxt_pc = ret_ff;
          nxt_state = st_run;
          nxt_done = 1'b1;
        end
        default: begin
          nxt_ir = prog_data;
          nxt_pc = pc_ff + 13'h0001;
          nxt_done = 1'b1;
          case (op)
            op_mov_a_m: nxt_acc = mval;
            op_mov_a_x: nxt_acc = maddr;
            op_mov_m_a: begin
              ram_we = 1'b1;
              ram_wdata = acc_ff;
            end
            op_add: begin
              sum = {1'b0, acc_ff} + {1'b0, mval};
              nxt_acc = sum[7:0];
              nxt_c = sum[8];
              nxt_z = (sum[7:0] == 8'h00);
            end
            op_sub: begin
              sum = {1'b0, acc_ff} - {1'b0, mval};
              nxt_acc = sum[7:0];
              nxt_c = ~sum[8];
              nxt_z = (sum[7:0] == 8'h00);
            end
            op_and, op_or, op_xor, op_complement: begin
              if (op == op_and) res = acc_ff & mval;
              else if (op == op_or) res = acc_ff | mval;
              else if (op == op_xor) res = acc_ff ^ mval;
              else res = ~mval;
              if (op == op_complement) begin
                ram_we = 1'b1;
                ram_wdata = res;
              end else begin
                nxt_acc = res;
              end
              nxt_z = (res == 8'h00);
            end
            op_inc_acc, op_inc_m, op_dec_acc, op_dec_m: begin
              if (op == op_inc_acc || op == op_inc_m) begin
                res = mval + 8'h01;
              end else begin
                res = mval - 8'h01;
              end
              nxt_z = (res == 8'h00);
              if (op == op_inc_m || op == op_dec_m) begin
                ram_we = 1'b1;
                ram_wdata = res;
              end else begin
                nxt_acc = res;
              end
            end
            op_rotate_right_via_carry: begin
              ram_we = 1'b1;
              ram_wdata = {c_ff, mval[7:1]};
              nxt_c = mval[0];
            end
            op_rotate_left_via_carry: begin
              ram_we = 1'b1;
              ram_wdata = {mval[6:0], c_ff};
              nxt_c = mval[7];
            end
            op_rr: begin
              ram_we = 1'b1;
              ram_wdata = {mval[0], mval[7:1]};
            end
            op_rl: begin
              ram_we = 1'b1;
              ram_wdata = {mval[6:0], mval[7]};
            end
            op_bit_set: begin
              ram_we = 1'b1;
              ram_wdata = mval | bit_mask(bsel);
            end
            op_bit_clear: begin
              ram_we = 1'b1;
              ram_wdata = mval & ~bit_mask(bsel);
            end
            op_unconditional_jump: begin
              nxt_pc = ir_ff[`TGT_MSB:0];
              nxt_state = st_flush;
              nxt_done = 1'b0;
            end
            op_call: begin
              nxt_stack[sp_ff[$clog2(STACK_DEPTH+1)-1:0] % STACK_DEPTH] = pc_ff;
              if (sp_ff < 4'(STACK_DEPTH)) nxt_sp = sp_ff + 4'h1;
              nxt_pc = ir_ff[`TGT_MSB:0];
              nxt_state = st_flush;
              nxt_done = 1'b0;
            end
            op_subroutine_exit: begin
              if (sp_ff != 4'h0) begin
                nxt_sp = sp_ff - 4'h1;
                nxt_pc = stack_ff[(sp_ff - 4'h1) % STACK_DEPTH];
              end
              nxt_state = st_flush;
              nxt_done = 1'b0;
            end
            op_skip_zero, op_skip_bit_zero, op_skip_bit_set: begin
              if ((op == op_skip_zero && mval == 8'h00) ||
                  (op == op_skip_bit_zero && !mval[bsel]) ||
                  (op == op_skip_bit_set && mval[bsel])) begin
                nxt_state = st_flush;
                nxt_done = 1'b0;
              end
            end
            op_table_read: begin
              nxt_pc = {5'h00, acc_ff};
              nxt_ret = pc_ff + 13'h0001;
              nxt_state = st_table;
              nxt_done = 1'b0;
            end
            op_halt: begin
              nxt_state = st_halted;
              nxt_pc = pc_ff;
              nxt_ir = ir_ff;
            end
            op_wdt_clear: nxt_wdt = 1'b1;
            default: ;
          endcase
          if (ram_we && maddr == `PCL_ADDR) begin
            nxt_pc = {pc_ff[12:8], ram_wdata};
            nxt_state = st_flush;
            nxt_done = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= st_run;
      pc_ff <= `PC_RESET;
      ir_ff <= 16'h0000;
      acc_ff <= `ACC_RESET;
      z_ff <= 1'b0;
      c_ff <= 1'b0;
      sp_ff <= 4'h0;
      tbl_ff <= 8'h00;
      ret_ff <= `PC_RESET;
      wdt_ff <= 1'b0;
      done_ff <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_ff[i] <= `PC_RESET;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      ir_ff <= nxt_ir;
      acc_ff <= nxt_acc;
      z_ff <= nxt_z;
      c_ff <= nxt_c;
      sp_ff <= nxt_sp;
      tbl_ff <= nxt_tbl;
      ret_ff <= nxt_ret;
      wdt_ff <= nxt_wdt;
      done_ff <= nxt_done;
      stack_ff <= nxt_stack;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign prog_addr = pc_ff;
  assign acc_out = acc_ff;
  assign zero_flag = z_ff;
  assign carry_flag = c_ff;
  assign halted = (state_ff == st_halted);
  assign wdt_clear = wdt_ff;
  assign table_data = tbl_ff;
  assign instr_done = done_ff;

endmodule : instr_timing_core
`default_nettype wire

// File: verilog/core_timing_consts.svh
/*
 Timing constants, opcode field positions and reset values for the
 instruction timing and control core. Included by the core and the phase counter.
*/
`ifndef CORE_TIMING_CONSTS_SVH
`define CORE_TIMING_CONSTS_SVH

`define PHASES_PER_CYCLE 4
`define PC_RESET 13'h0000
`define ACC_RESET 8'h00
`define PCL_ADDR 8'h06
`define OPC_MSB 15
`define OPC_LSB 11
`define BIT_MSB 10
`define BIT_LSB 8
`define ADDR_MSB 7
`define ADDR_LSB 0
`define TGT_MSB 12

`endif

// File: verilog/core_timing_pkg.sv
/*
 Types for the instruction timing and control core.
 Assumes the constants header is compiled alongside.
*/
package core_timing_pkg;

  typedef enum logic [4:0] {
    op_nop, op_mov_a_m, op_mov_m_a, op_mov_a_x, op_add, op_sub,
    op_and, op_or, op_xor, op_complement, op_inc_acc, op_dec_acc,
    op_inc_m, op_dec_m, op_rotate_right_via_carry,
    op_rotate_left_via_carry, op_rr, op_rl, op_bit_set, op_bit_clear,
    op_unconditional_jump, op_call, op_subroutine_exit, op_skip_zero,
    op_skip_bit_zero, op_skip_bit_set, op_table_read, op_halt, op_wdt_clear
  } opcode_type;

  typedef enum {
    st_run, st_flush, st_table, st_halted
  } core_state_type;

endpackage : core_timing_pkg

// File: verilog/phase_counter.sv
/*
 Divides the system clock into four-phase instruction cycles.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_timing_consts.svh"

module phase_counter #(
  parameter int PHASES = `PHASES_PER_CYCLE
) (
  input wire logic mclk,
  input wire logic reset,
  output logic cycle_end
);

  initial begin
    if (PHASES < 2) $error("phase count too small");
  end

  logic [7:0] phase_ff;
  logic [7:0] nxt_phase;

  always_comb begin
    nxt_phase = phase_ff + 8'h01;
    if (phase_ff == 8'(PHASES - 1)) begin
      nxt_phase = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      phase_ff <= 8'h00;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign cycle_end = (phase_ff == 8'(PHASES - 1));

endmodule : phase_counter
`default_nettype wire

// File: verilog/data_ram.sv
/*
 Data memory sector 0, single port, registered read data.
 Assumes one clock; no reset of contents.
*/
`timescale 1ns/1ps
`default_nettype none

module data_ram #(
  parameter int DEPTH = 256
) (
  input wire logic mclk,
  input wire logic [7:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  initial begin
    if (DEPTH < 2 || DEPTH > 256) $error("bad ram depth");
  end

  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_ff;

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end

  assign rdata = rdata_ff;

endmodule : data_ram
`default_nettype wire

// File: verif/instr_timing_core_sva.sv
/*
 Checker for the instruction timing core: output holding and pacing.
 Assumes binding onto the core top, one clock, sync active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module instr_timing_core_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [12:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic wake,
  input wire logic [7:0] acc_out,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic halted,
  input wire logic wdt_clear,
  input wire logic [7:0] table_data,
  input wire logic instr_done
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence hold3(sig);
    $stable(sig) [*3];
  endsequence

  chk_cycle_span: assert property (instr_done |=> !instr_done [*3])
    else $error("retire pulses closer than four clocks");
  chk_addr_hold: assert property ($changed(prog_addr) |=> hold3(prog_addr))
    else $error("fetch address held under four clocks");
  chk_acc_hold: assert property ($changed(acc_out) |=> hold3(acc_out))
    else $error("accumulator changed twice in a cycle");
  chk_flag_hold: assert property ($changed({zero_flag, carry_flag})
    |=> hold3({zero_flag, carry_flag}))
    else $error("flags changed twice in a cycle");
  chk_table_hold: assert property ($changed(table_data) |=> hold3(table_data))
    else $error("table byte changed twice in a cycle");
  chk_wdt_pulse: assert property (wdt_clear |=> !wdt_clear [*3])
    else $error("watchdog clear pulse too long");
  chk_halt_quiet: assert property (halted [*3]
    |-> !instr_done && $stable(prog_addr))
    else $error("activity while halted");
  chk_wake_exit: assert property (halted && wake |-> ##[1:7] !halted)
    else $error("wake did not end halt in time");
endmodule : instr_timing_core_sva

bind instr_timing_core instr_timing_core_sva chk_u (.mclk(mclk),
  .reset(reset), .prog_addr(prog_addr), .prog_data(prog_data),
  .wake(wake), .acc_out(acc_out), .zero_flag(zero_flag),
  .carry_flag(carry_flag), .halted(halted), .wdt_clear(wdt_clear),
  .table_data(table_data), .instr_done(instr_done));
`default_nettype wire

// File: verif/mcu_instruction_timing_control_tb.sv
/*
 Testbench for the instruction timing core: program memory model,
 expected-result queue and retire monitor. Assumes the core files.
*/
`timescale 1ns/1ps
`default_nettype none

module mcu_instruction_timing_control_tb;
  import core_timing_pkg::*;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] gap;
    logic [1:0] fm;
    logic [1:0] fv;
  } note_type;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wake;
  logic [15:0] prog_data;
  logic [12:0] prog_addr;
  logic [7:0] acc_out;
  logic zero_flag;
  logic carry_flag;
  logic halted;
  logic wdt_clear;
  logic [7:0] table_data;
  logic instr_done;
  logic [15:0] rom [0:8191];
  logic [7:0] rnd;
  note_type notes[$];
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last = 0;

  instr_timing_core dut_u (.mclk(mclk), .reset(reset),
    .prog_addr(prog_addr), .prog_data(prog_data), .wake(wake),
    .acc_out(acc_out), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .halted(halted), .wdt_clear(wdt_clear), .table_data(table_data),
    .instr_done(instr_done));

  always #4 mclk = ~mclk;
  always @(negedge mclk) prog_data <= rom[prog_addr];

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ins(input logic [12:0] a, input opcode_type o,
    input logic [10:0] f, input logic [7:0] acc, input logic [7:0] gap,
    input logic [1:0] fm = 2'b00, input logic [1:0] fv = 2'b00);
    rom[a] = {o, f};
    notes.push_back('{acc, gap, fm, fv});
  endtask : ins

  task automatic summarize();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Retire monitor
  // ----------------------------------------------------------------
  always @(negedge mclk) begin
    note_type n;
    cyc++;
    if (!reset && instr_done === 1'b1) begin
      if (notes.size() > 0) begin
        n = notes.pop_front();
        check(acc_out, n.acc);
        if (n.gap != 8'h00) check(8'(cyc - last), n.gap);
        check({6'h00, {zero_flag, carry_flag} & n.fm}, {6'h00, n.fv});
      end
      else begin
        miscompares++;
        $display("unexpected at %0t: retire %h note %h", $time, acc_out, 8'h00);
      end
      last = cyc;
    end
  end

  initial begin
    #(8 * 2000);
    miscompares++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Program and main sequence
  // ----------------------------------------------------------------
  initial begin
    wake = 1'b0;
    prog_data = 16'h0000;
    for (int i = 0; i < 8192; i++) rom[i] = 16'h0000;
    void'($urandom(32'h7982));
    rnd = 8'($urandom());
    rom[13'h088] = 16'h00a5;
    notes.push_back('{8'h00, 8'h00, 2'b00, 2'b00});
    ins(0, op_mov_a_x, 11'h05a, 8'h5a, 0);
    ins(1, op_mov_m_a, 11'h010, 8'h5a, 4);
    ins(2, op_xor, 11'h010, 8'h00, 4, 2'b10, 2'b10);
    ins(3, op_mov_a_x, 11'h0ff, 8'hff, 4);
    ins(4, op_mov_m_a, 11'h011, 8'hff, 4);
    ins(5, op_mov_a_x, 11'h001, 8'h01, 4);
    ins(6, op_add, 11'h011, 8'h00, 4, 2'b01, 2'b01);
    ins(7, op_sub, 11'h011, 8'h01, 4, 2'b01, 2'b00);
    ins(8, op_dec_acc, 11'h011, 8'hfe, 4);
    ins(9, op_bit_clear, 11'h011, 8'hfe, 4);
    ins(10, op_mov_a_m, 11'h011, 8'hfe, 4);
    ins(11, op_skip_bit_zero, 11'h011, 8'hfe, 8);
    rom[12] = {op_mov_a_x, 11'h033};
    ins(13, op_call, 11'h020, 8'hfe, 8);
    ins(13'h820, op_mov_a_x, 11'h077, 8'h77, 4);
    ins(13'h821, op_subroutine_exit, 11'h000, 8'h77, 8);
    ins(14, op_skip_bit_set, 11'h011, 8'h77, 4);
    ins(15, op_unconditional_jump, 11'h030, 8'h77, 8);
    rom[16] = {op_mov_a_x, 11'h066};
    ins(13'h030, op_mov_a_x, {3'd0, rnd}, rnd, 4);
    ins(13'h031, op_halt, 11'h000, rnd, 4);
    ins(13'h032, op_wdt_clear, 11'h000, rnd, 0);
    ins(13'h033, op_mov_a_x, 11'h040, 8'h40, 4);
    ins(13'h034, op_mov_m_a, 11'h006, 8'h40, 8);
    ins(13'h040, op_mov_a_x, 11'h088, 8'h88, 4);
    ins(13'h041, op_table_read, 11'h000, 8'h88, 8);
    ins(13'h042, op_mov_a_x, 11'h099, 8'h99, 4);
    ins(13'h043, op_rotate_left_via_carry, 11'h011, 8'h99, 4);
    ins(13'h044, op_mov_a_m, 11'h011, 8'hfc, 4, 2'b01, 2'b01);
    ins(13'h045, op_rotate_right_via_carry, 11'h011, 8'hfc, 4);
    ins(13'h046, op_mov_a_m, 11'h011, 8'hfe, 4, 2'b01, 2'b00);
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    for (int i = 0; i < 400 && halted !== 1'b1; i++) @(negedge mclk);
    check({7'h00, halted}, 8'h01);
    repeat (12) @(negedge mclk);
    wake = 1'b1;
    for (int i = 0; i < 20 && halted !== 1'b0; i++) @(negedge mclk);
    wake = 1'b0;
    for (int i = 0; i < 40 && wdt_clear !== 1'b1; i++) @(negedge mclk);
    check({7'h00, wdt_clear}, 8'h01);
    for (int i = 0; i < 400 && notes.size() > 0; i++) @(negedge mclk);
    check(8'(notes.size()), 8'h00);
    check(table_data, 8'ha5);
    summarize();
  end
endmodule : mcu_instruction_timing_control_tb
`default_nettype wire
